// [rtl/motion_cmd_pkg.sv]
// Purpose: Shared constants for the motion input command logic
// Assumes: 100 MHz clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit registers
package motion_cmd_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] CFG_OFFS = 8'h00;
   localparam logic [7:0] DATA_SEL_OFFS = 8'h04;
   localparam logic [7:0] PRESET_OFFS = 8'h08;
   localparam logic [7:0] STATUS_OFFS = 8'h0C;
   localparam logic [7:0] CMD_POS_OFFS = 8'h10;
   localparam logic [7:0] FB_POS_OFFS = 8'h14;
   localparam logic [7:0] EL_HOME_OFFS = 8'h18;
   localparam logic [7:0] SPEED_OFFS = 8'h1C;
   // ==========================================================
   // Field positions in the configuration register
   localparam int LIMIT_ACT_LSB = 0;
   localparam int HOME_MODE_LSB = 4;
   localparam int SLIT_EN_BIT = 8;
   // ==========================================================
   // Reset values and the speed step per entry
   localparam logic [2:0] LIMIT_ACT_RST = 3'h2;
   localparam logic [1:0] HOME_MODE_RST = 2'h1;
   localparam logic [31:0] PRESET_RST = 32'h0000_0000;
   localparam logic [31:0] SPEED_STEP = 32'h0000_0064;
   // ==========================================================
   // Limit-input action codes (3-bit two's complement)
   localparam logic [2:0] LIM_HOME_ONLY = 3'h7;
   localparam logic [2:0] LIM_IMM = 3'h0;
   localparam logic [2:0] LIM_DEC = 3'h1;
   localparam logic [2:0] LIM_IMM_ALM = 3'h2;
   localparam logic [2:0] LIM_DEC_ALM = 3'h3;
   // ==========================================================
   // Home-seeking modes and run modes
   typedef enum logic [1:0] {
      HOME_TWO = 2'b00,
      HOME_THREE = 2'b01,
      HOME_ONEWAY = 2'b10,
      HOME_PUSH = 2'b11
   } home_mode_t;
   typedef enum logic [2:0] {
      RUN_IDLE = 3'b000,
      RUN_INCH = 3'b001,
      RUN_COMBO = 3'b010,
      RUN_CONT = 3'b011,
      RUN_SPEED = 3'b100,
      RUN_PUSH = 3'b101,
      RUN_HOME = 3'b110
   } run_mode_t;
endpackage

// [rtl/motion_input_command_logic.sv]
// Purpose: Discrete command/sensor input logic of a stepping motor driver
// Assumes: Motion profile generator outside follows the run commands given
// Notes: Registers are reached over AXI4-Lite
// Behaviour
// - Inching input starts an inching move in its direction.
// - Combined jog input starts a combined jog in its direction.
// - Continuous input with data selected starts continuous run at entry speed.
// - Speed-control input starts speed-control run at entry speed.
// - Push input starts push-motion run at entry speed.
// - Same-direction input during deceleration resumes acceleration.
// - Both directions together during continuous, speed-control or push run make the motor decelerate to stop.
// - Changing data number mid-run changes speed to new entry.
// - Limit during homing is handled by home-seeking mode.
// - Limit outside homing stops motor unless set homing only.
// - Limit action decode -1..3, default 2.
// - Home mode decode 0..3, default 1.
// - Home sensor used only in three-sensor or one-way mode.
// - Slit sensor may combine with home sensor during homing.
// - Preset overwrites command and feedback positions.
// - Accepted preset also writes non-volatile memory.
// - Preset ignored while operating or paused.
// - Preset refused while deviation flag set.
// - Electrical home rising edge captures coordinates, used while held.
// - Electrical home release returns to mechanical coordinates.
// - Electrical home mid-move rebases positions, target stays mechanical.
// - High-speed homing refused while electrical home held.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module motion_input_command_logic
   import motion_cmd_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Command inputs
   input wire logic fwd_inch_in,
   input wire logic rev_inch_in,
   input wire logic fwd_combo_jog_in,
   input wire logic rev_combo_jog_in,
   input wire logic fwd_continuous_in,
   input wire logic rev_continuous_in,
   input wire logic fwd_speed_ctrl_in,
   input wire logic rev_speed_ctrl_in,
   input wire logic fwd_push_in,
   input wire logic rev_push_in,
   input wire logic home_req_in,
   input wire logic fast_home_req_in,
   input wire logic preset_req_in,
   input wire logic pause_in,
   input wire logic electrical_home_in,
   // Sensor inputs
   input wire logic fwd_limit_sensor_in,
   input wire logic rev_limit_sensor_in,
   input wire logic home_sensor_in,
   input wire logic slit_sensor_in,
   // Motion engine status
   input wire logic motor_busy_in,
   input wire logic decel_in,
   input wire logic home_done_in,
   input wire logic step_fwd_in,
   input wire logic step_rev_in,
   input wire logic [31:0] fb_delta_in,
   // Motion engine commands
   output logic [2:0] run_mode_out,
   output logic run_dir_rev_out,
   output logic run_start_out,
   output logic decel_stop_out,
   output logic imm_stop_out,
   output logic [31:0] run_speed_out,
   output logic overtravel_alarm_out,
   output logic home_edge_out,
   output logic fast_home_start_out,
   output logic nvm_write_out,
   output logic [31:0] nvm_data_out,
   output logic deviation_flag_out,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================================
   // Input synchronisers and on-edge detection
   localparam int NIN = 20;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync1_reg;
   logic [NIN-1:0] sync2_reg;
   logic [NIN-1:0] prev_reg;
   logic [NIN-1:0] rise;
   assign raw_in = {slit_sensor_in, home_sensor_in, rev_limit_sensor_in, fwd_limit_sensor_in,
      electrical_home_in, pause_in, preset_req_in, fast_home_req_in, home_req_in,
      rev_push_in, fwd_push_in, rev_speed_ctrl_in, fwd_speed_ctrl_in,
      rev_continuous_in, fwd_continuous_in, rev_combo_jog_in, fwd_combo_jog_in,
      rev_inch_in, fwd_inch_in, 1'b0};
   // Two flops then edge register
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end
   assign rise = sync2_reg & ~prev_reg;
   logic s_fi, s_ri, s_fj, s_rj, s_fc, s_rc, s_fs, s_rs, s_fp, s_rp;
   logic s_home, s_fhome, s_pre, s_pause, s_el, s_flim, s_rlim, s_hs, s_slit;
   assign {s_slit, s_hs, s_rlim, s_flim, s_el, s_pause, s_pre, s_fhome, s_home,
      s_rp, s_fp, s_rs, s_fs, s_rc, s_fc, s_rj, s_fj, s_ri, s_fi} = sync2_reg[NIN-1:1];
   logic e_fi, e_ri, e_fj, e_rj, e_fc, e_rc, e_fs, e_rs, e_fp, e_rp;
   logic e_home, e_fhome, e_pre, e_pause, e_el, e_flim, e_rlim, e_hs, e_slit;
   assign {e_slit, e_hs, e_rlim, e_flim, e_el, e_pause, e_pre, e_fhome, e_home,
      e_rp, e_fp, e_rs, e_fs, e_rc, e_fc, e_rj, e_fj, e_ri, e_fi} = rise[NIN-1:1];
   logic el_fall;
   assign el_fall = prev_reg[15] & ~sync2_reg[15];

   // ==========================================================
   // Software registers
   logic [2:0] limit_act_reg;
   logic [1:0] home_mode_reg;
   logic slit_en_reg;
   logic [7:0] data_sel_reg;
   logic [31:0] preset_reg;
   logic [31:0] cmd_pos_reg;
   logic [31:0] fb_pos_reg;
   logic [31:0] el_base_reg;
   logic el_active_reg;
   logic [31:0] dev_limit;
   logic [31:0] deviation;
   assign dev_limit = 32'h0000_1000;

   // Speed of the selected entry: entry index times a fixed step
   logic [31:0] entry_speed;
   assign entry_speed = SPEED_STEP * {24'h00_0000, data_sel_reg};

   // ==========================================================
   // Run command state
   run_mode_t mode_reg;
   logic dir_reg;
   logic start_reg;
   logic dstop_reg;
   logic istop_reg;
   logic ot_alm_reg;
   logic cont_like;
   logic both_dir;
   logic fwd_lvl;
   logic rev_lvl;
   logic home_only;
   logic limit_hit;
   logic dec_action;
   home_mode_t hmode;
   assign hmode = home_mode_t'(home_mode_reg);
   assign cont_like = (mode_reg == RUN_CONT) || (mode_reg == RUN_SPEED) || (mode_reg == RUN_PUSH);
   assign fwd_lvl = (mode_reg == RUN_CONT) ? s_fc : (mode_reg == RUN_SPEED) ? s_fs : s_fp;
   assign rev_lvl = (mode_reg == RUN_CONT) ? s_rc : (mode_reg == RUN_SPEED) ? s_rs : s_rp;
   assign both_dir = cont_like && fwd_lvl && rev_lvl && !dstop_reg && !decel_in; // Blocked while a stop pulse or deceleration is under way
   assign home_only = (limit_act_reg == LIM_HOME_ONLY);
   assign dec_action = (limit_act_reg == LIM_DEC) || (limit_act_reg == LIM_DEC_ALM);
   assign limit_hit = (e_flim || e_rlim) && (mode_reg != RUN_HOME) && !home_only;

   // Mode, direction and stop commands
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_reg <= RUN_IDLE;
         dir_reg <= 1'b0;
         start_reg <= 1'b0;
         dstop_reg <= 1'b0;
         istop_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         dstop_reg <= 1'b0;
         istop_reg <= 1'b0;
         if (limit_hit) begin
            dstop_reg <= dec_action;
            istop_reg <= !dec_action;
            mode_reg <= RUN_IDLE;
         end else if (both_dir) begin
            dstop_reg <= 1'b1;
         end else if (cont_like && decel_in && (dir_reg ? rev_lvl : fwd_lvl) &&
                      (dir_reg ? (e_rc || e_rs || e_rp) : (e_fc || e_fs || e_fp))) begin
            start_reg <= 1'b1;
         end else if (!motor_busy_in) begin
            mode_reg <= start_reg ? mode_reg : RUN_IDLE; // Hold until the engine reports busy
            if (e_fi || e_ri) begin
               mode_reg <= RUN_INCH;
               dir_reg <= e_ri;
               start_reg <= 1'b1;
            end else if (e_fj || e_rj) begin
               mode_reg <= RUN_COMBO;
               dir_reg <= e_rj;
               start_reg <= 1'b1;
            end else if ((e_fc || e_rc) && !(s_fc && s_rc)) begin
               mode_reg <= RUN_CONT;
               dir_reg <= e_rc;
               start_reg <= 1'b1;
            end else if ((e_fs || e_rs) && !(s_fs && s_rs)) begin
               mode_reg <= RUN_SPEED;
               dir_reg <= e_rs;
               start_reg <= 1'b1;
            end else if ((e_fp || e_rp) && !(s_fp && s_rp)) begin
               mode_reg <= RUN_PUSH;
               dir_reg <= e_rp;
               start_reg <= 1'b1;
            end else if (e_home) begin
               mode_reg <= RUN_HOME;
               start_reg <= 1'b1;
            end
         end else if (mode_reg == RUN_HOME && home_done_in) begin
            mode_reg <= RUN_IDLE;
         end
      end
   end

   // Overtravel alarm, sticky until a new start
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ot_alm_reg <= 1'b0;
      end else if (limit_hit && (limit_act_reg == LIM_IMM_ALM || limit_act_reg == LIM_DEC_ALM)) begin
         ot_alm_reg <= 1'b1;
      end else if (start_reg) begin
         ot_alm_reg <= 1'b0;
      end
   end

   // Running speed follows the selected entry in every mode
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run_speed_out <= '0;
      end else begin
         run_speed_out <= entry_speed;
      end
   end

   // Home edge: limits per mode, home sensor in 3-sensor and one-way, slit optional
   logic home_use_hs;
   logic home_ev;
   assign home_use_hs = (hmode == HOME_THREE) || (hmode == HOME_ONEWAY);
   always_comb begin
      home_ev = 1'b0;
      if (mode_reg == RUN_HOME) begin
         unique case (hmode)
            HOME_TWO: home_ev = e_flim || e_rlim;
            HOME_THREE: home_ev = e_hs || e_flim || e_rlim;
            HOME_ONEWAY: home_ev = e_hs;
            HOME_PUSH: home_ev = 1'b0;
         endcase
         if (home_use_hs && slit_en_reg) begin
            home_ev = home_ev && !(e_hs && !s_slit);
            home_ev = home_ev || (e_slit && s_hs);
         end
      end
   end
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         home_edge_out <= 1'b0;
         fast_home_start_out <= 1'b0;
      end else begin
         home_edge_out <= home_ev;
         fast_home_start_out <= e_fhome && !s_el && !motor_busy_in;
      end
   end

   // ==========================================================
   // Positions, preset and electrical home
   logic preset_ok;
   assign deviation = cmd_pos_reg - fb_pos_reg;
   assign preset_ok = e_pre && !motor_busy_in && !s_pause && !deviation_flag_out;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cmd_pos_reg <= '0;
         fb_pos_reg <= '0;
      end else if (preset_ok) begin
         cmd_pos_reg <= preset_reg;
         fb_pos_reg <= preset_reg;
      end else begin
         cmd_pos_reg <= cmd_pos_reg + (step_fwd_in ? 32'h1 : 32'h0) - (step_rev_in ? 32'h1 : 32'h0);
         fb_pos_reg <= fb_pos_reg + fb_delta_in;
      end
   end
   // Non-volatile write strobe alongside the preset
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nvm_write_out <= 1'b0;
         nvm_data_out <= '0;
      end else begin
         nvm_write_out <= preset_ok;
         if (preset_ok) begin
            nvm_data_out <= preset_reg;
         end
      end
   end
   // Deviation flag from command/feedback difference
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         deviation_flag_out <= 1'b0;
      end else begin
         deviation_flag_out <= ($signed(deviation) > $signed(dev_limit)) ||
                               ($signed(deviation) < -$signed(dev_limit));
      end
   end
   // Electrical home base; targets stay mechanical since base only offsets reads
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         el_base_reg <= '0;
         el_active_reg <= 1'b0;
      end else if (e_el) begin
         el_base_reg <= cmd_pos_reg;
         el_active_reg <= 1'b1;
      end else if (el_fall) begin
         el_base_reg <= '0;
         el_active_reg <= 1'b0;
      end
   end

   assign run_mode_out = mode_reg;
   assign run_dir_rev_out = dir_reg;
   assign run_start_out = start_reg;
   assign decel_stop_out = dstop_reg;
   assign imm_stop_out = istop_reg;
   assign overtravel_alarm_out = ot_alm_reg;

   // ==========================================================
   // AXI4-Lite write channel
   logic aw_ok_reg;
   logic w_ok_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_ok_reg && !s_axi_bvalid;
   assign s_axi_bresp = 2'h0;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (aw_ok_reg && w_ok_reg) begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Register writes, lane 0 for limit and home fields, lane 1 for slit enable
   logic wr_go;
   assign wr_go = aw_ok_reg && w_ok_reg;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         limit_act_reg <= LIMIT_ACT_RST;
         home_mode_reg <= HOME_MODE_RST;
         slit_en_reg <= 1'b0;
         data_sel_reg <= '0;
         preset_reg <= PRESET_RST;
      end else if (wr_go) begin
         if (aw_addr_reg == CFG_OFFS) begin
            if (w_strb_reg[0]) begin
               limit_act_reg <= w_data_reg[LIMIT_ACT_LSB +: 3];
               home_mode_reg <= w_data_reg[HOME_MODE_LSB +: 2];
            end
            if (w_strb_reg[1]) begin
               slit_en_reg <= w_data_reg[SLIT_EN_BIT];
            end
         end
         if (aw_addr_reg == DATA_SEL_OFFS && w_strb_reg[0]) begin
            data_sel_reg <= w_data_reg[7:0];
         end
         if (aw_addr_reg == PRESET_OFFS) begin
            for (int b = 0; b < 4; b++) begin
               if (w_strb_reg[b]) begin
                  preset_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
               end
            end
         end
      end
   end
   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (s_axi_araddr)
         CFG_OFFS: rd_mux = {23'h0, slit_en_reg, 2'h0, home_mode_reg, 1'b0, limit_act_reg};
         DATA_SEL_OFFS: rd_mux = {24'h0, data_sel_reg};
         PRESET_OFFS: rd_mux = preset_reg;
         STATUS_OFFS: rd_mux = {22'h0, el_active_reg, deviation_flag_out, ot_alm_reg,
                                dir_reg, 3'h0, mode_reg};
         CMD_POS_OFFS: rd_mux = cmd_pos_reg - el_base_reg;
         FB_POS_OFFS: rd_mux = fb_pos_reg - el_base_reg;
         EL_HOME_OFFS: rd_mux = el_base_reg;
         SPEED_OFFS: rd_mux = run_speed_out;
         default: rd_mux = '0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   inch_start_a: assert property (e_fi && !motor_busy_in && !limit_hit && !both_dir |=>
      run_start_out && run_mode_out == RUN_INCH && !run_dir_rev_out) else $error("inch fail");
   both_dir_a: assert property (both_dir && !limit_hit |=> decel_stop_out)
      else $error("both dir no stop");
   limit_stop_a: assert property (limit_hit |=> decel_stop_out || imm_stop_out)
      else $error("limit no stop");
   home_only_a: assert property (home_only && mode_reg != RUN_HOME |=> !imm_stop_out && !decel_stop_out
      || $past(both_dir)) else $error("home-only stopped");
   preset_load_a: assert property (preset_ok |=> cmd_pos_reg == $past(preset_reg) && nvm_write_out)
      else $error("preset not loaded");
   preset_busy_a: assert property (motor_busy_in || s_pause || deviation_flag_out |=> !nvm_write_out)
      else $error("preset while busy");
   el_home_a: assert property (e_el |=> el_active_reg && el_base_reg == $past(cmd_pos_reg))
      else $error("el home capture");
   fast_home_a: assert property (s_el |=> !fast_home_start_out)
      else $error("fast home while el");
   sync_edge_a: assert property (run_start_out |-> $past(|rise[NIN-1:1]) || $past(cont_like))
      else $error("start without edge");
   cont_cv: cover property (e_fc ##1 run_mode_out == RUN_CONT);
   resume_cv: cover property (decel_in && cont_like ##1 run_start_out);
   preset_cv: cover property (nvm_write_out);
   el_cv: cover property (el_active_reg ##[1:5] !el_active_reg);
endmodule

// [bench/motion_engine_model.sv]
// Purpose: Motion engine stand-in that answers run commands
// Assumes: A run lasts 40 cycles, the last 8 decelerating
// Notes: A start during deceleration restarts the run
`timescale 1ns/1ps
module motion_engine_model (
   // Clock, reset and commands
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic dec_in,
   input wire logic imm_in,
   // Status back to the block
   output logic busy_out,
   output logic decel_out
);
   logic [5:0] cnt_reg;
   // ==========================================
   // Run timer; an immediate stop ends the run at once
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= 6'h00;
      end else if (imm_in) begin
         cnt_reg <= 6'h00;
      end else if (start_in) begin
         cnt_reg <= 6'h28;
      end else if (dec_in && cnt_reg > 6'h08) begin
         cnt_reg <= 6'h08;
      end else if (cnt_reg != 6'h00) begin
         cnt_reg <= cnt_reg - 6'h01;
      end
   end
   // Status decode
   assign busy_out = cnt_reg != 6'h00;
   assign decel_out = busy_out && cnt_reg <= 6'h08; // Tail of the run
endmodule

// [bench/tb.sv]
// Purpose: Self-checking bench for the motion input command logic
// Assumes: Engine model answers run commands
// Notes: Pulses are counted, then counts compared
`timescale 1ns/1ps
module tb;
   import motion_cmd_pkg::*;
   logic mclk_in = 0, sys_rst_in = 1, pause_in = 0, electrical_home_in = 0, preset_req_in = 0;
   logic fast_home_req_in = 0, fwd_limit_sensor_in = 0, rev_limit_sensor_in = 0, step_fwd_in = 0;
   logic [10:0] cmd = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire logic fwd_inch_in, rev_inch_in, fwd_combo_jog_in, rev_combo_jog_in, fwd_continuous_in;
   wire logic rev_continuous_in, fwd_speed_ctrl_in, rev_speed_ctrl_in, fwd_push_in, rev_push_in;
   wire logic home_req_in, motor_busy_in, decel_in, run_dir_rev_out, run_start_out, decel_stop_out;
   wire logic imm_stop_out, overtravel_alarm_out, home_edge_out, fast_home_start_out, nvm_write_out;
   wire logic deviation_flag_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [2:0] run_mode_out;
   wire logic [31:0] run_speed_out, nvm_data_out, s_axi_rdata;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares = 0, num_checks = 0, n_start = 0, n_dec = 0, n_imm = 0, n_nvm = 0, n_fast = 0;
   assign {home_req_in, rev_push_in, fwd_push_in, rev_speed_ctrl_in, fwd_speed_ctrl_in, rev_continuous_in,
      fwd_continuous_in, rev_combo_jog_in, fwd_combo_jog_in, rev_inch_in, fwd_inch_in} = cmd;
   // ==========================================
   // Design and far-side model
   motion_input_command_logic motion_input_command_logic_inst (.mclk_in, .sys_rst_in, .fwd_inch_in,
      .rev_inch_in, .fwd_combo_jog_in, .rev_combo_jog_in, .fwd_continuous_in, .rev_continuous_in,
      .fwd_speed_ctrl_in, .rev_speed_ctrl_in, .fwd_push_in, .rev_push_in, .home_req_in, .fast_home_req_in,
      .preset_req_in, .pause_in, .electrical_home_in, .fwd_limit_sensor_in, .rev_limit_sensor_in,
      .home_sensor_in(1'b0), .slit_sensor_in(1'b0), .motor_busy_in, .decel_in, .home_done_in(1'b0),
      .step_fwd_in, .step_rev_in(1'b0), .fb_delta_in(32'h0000_0000), .run_mode_out, .run_dir_rev_out,
      .run_start_out, .decel_stop_out, .imm_stop_out, .run_speed_out, .overtravel_alarm_out, .home_edge_out,
      .fast_home_start_out, .nvm_write_out, .nvm_data_out, .deviation_flag_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   motion_engine_model motion_engine_model_inst (.clk_in(mclk_in), .rst_in(sys_rst_in),
      .start_in(run_start_out), .dec_in(decel_stop_out), .imm_in(imm_stop_out), .busy_out(motor_busy_in),
      .decel_out(decel_in));
   // Clock at 100 MHz
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   // Pulse counters
   always @(posedge mclk_in) begin
      n_start <= n_start + run_start_out;
      n_dec <= n_dec + decel_stop_out;
      n_imm <= n_imm + imm_stop_out;
      n_nvm <= n_nvm + nvm_write_out;
      n_fast <= n_fast + fast_home_start_out;
   end
   // ==========================================
   // Tasks
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdw(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge mclk_in); // Gap before the next read
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200us;
      miscompares++;
      results();
   end
   // ==========================================
   // Test sequence
   initial begin
      step(12);
      sys_rst_in <= 1'b0;
      step(2);
      rdw(CFG_OFFS);
      chk(rd, 32'h0000_0012);
      rdw(8'h40);
      chk(rd, 32'h0000_0000);
      wr(DATA_SEL_OFFS, 32'h0000_0003);
      // Every run command input, each direction
      for (int i = 0; i < 11; i++) begin
         cmd[i] <= 1'b1;
         step(8);
         chk(32'(n_start), 32'(i + 1));
         chk(32'(run_mode_out), (i < 10) ? 32'(i / 2 + 1) : 32'(RUN_HOME));
         if (i < 10) chk(32'(run_dir_rev_out), 32'(i % 2));
         if (i > 3 && i < 10) chk(run_speed_out, 32'h0000_012C);
         cmd[i] <= 1'b0;
         step(45);
      end
      // Speed change mid-run, then limit hit
      cmd[4] <= 1'b1;
      step(8);
      wr(DATA_SEL_OFFS, 32'h0000_0005);
      step(3);
      chk(run_speed_out, 32'h0000_01F4);
      fwd_limit_sensor_in <= 1'b1;
      step(6);
      chk(32'(n_imm), 32'h1);
      chk(32'(overtravel_alarm_out), 32'h1);
      fwd_limit_sensor_in <= 1'b0;
      cmd[4] <= 1'b0;
      step(45);
      // Homing-only limit action, then both directions
      wr(CFG_OFFS, 32'h0000_0017);
      cmd[4] <= 1'b1;
      step(8);
      fwd_limit_sensor_in <= 1'b1;
      step(6);
      chk(32'(n_imm), 32'h1);
      cmd[5] <= 1'b1;
      step(6);
      chk(32'(n_dec), 32'h1);
      cmd <= 11'h000;
      fwd_limit_sensor_in <= 1'b0;
      step(1);
      cmd[4] <= 1'b1;
      step(5);
      chk(32'(n_start), 32'hE);
      cmd[4] <= 1'b0;
      step(45);
      // Preset accepted, then refused while paused
      wr(PRESET_OFFS, 32'h0000_1234);
      preset_req_in <= 1'b1;
      step(6);
      chk(32'(n_nvm), 32'h1);
      rdw(CMD_POS_OFFS);
      chk(rd, 32'h0000_1234);
      rdw(FB_POS_OFFS);
      chk(rd, 32'h0000_1234);
      preset_req_in <= 1'b0;
      pause_in <= 1'b1;
      step(2);
      preset_req_in <= 1'b1;
      step(6);
      chk(32'(n_nvm), 32'h1);
      preset_req_in <= 1'b0;
      pause_in <= 1'b0;
      // Electrical home blocks fast homing
      electrical_home_in <= 1'b1;
      fast_home_req_in <= 1'b1;
      step(6);
      chk(32'(n_fast), 32'h0);
      fast_home_req_in <= 1'b0;
      electrical_home_in <= 1'b0;
      step(4);
      fast_home_req_in <= 1'b1;
      step(6);
      chk(32'(n_fast), 32'h1);
      results();
   end
endmodule
